// file: hdl/kmh_port.v
// One host channel of the two-wire keyboard and pointer serial link.
`timescale 1ns/1ns
`include "kmh_map.vh"
module kmh_port #(
   parameter TIMEOUT_CYC = `KMH_TIMEOUT_CYC,
   parameter INHIBIT_CYC = `KMH_INHIBIT_CYC,
   parameter TRANSLATE_EN = 1
) (
   // Clock and reset.
   input wire clock,
   input wire rstn,
   // Control.
   input wire [1:0] mode,
   input wire lock,
   input wire translate,
   // Command request.
   input wire cmd_valid,
   input wire [7:0] cmd_data,
   output reg cmd_ready,
   output reg cmd_done,
   output reg cmd_nak,
   // Received bytes.
   output reg rx_valid,
   output reg [7:0] rx_data,
   output reg rx_parity_err,
   output reg timeout_err,
   output reg irq,
   // Link pins, open drain.
   input wire link_clk_in,
   output reg link_clk_out,
   output reg link_clk_oe,
   input wire link_data_in,
   output reg link_data_out,
   output reg link_data_oe
);
   localparam S_IDLE = 6'b000001;
   localparam S_RX = 6'b000010;
   localparam S_INH = 6'b000100;
   localparam S_TX = 6'b001000;
   localparam S_ACK = 6'b010000;
   localparam S_POST = 6'b100000;

   reg [1:0] clk_sync_r;
   reg [1:0] dat_sync_r;
   reg clk_prev_r;
   reg [5:0] state_r;
   reg [3:0] bit_cnt_r;
   reg [10:0] shift_r;
   reg [31:0] timer_r;
   reg break_r;

   function odd_par;
      input [7:0] d;
      begin
         odd_par = ~(^d);
      end
   endfunction

   // Simple translation: set 2 scan break prefix folds into bit 7 of the next code.
   function [7:0] xlate;
      input [7:0] code;
      input brk;
      begin
         xlate = brk ? (code | 8'h80) : code;
      end
   endfunction

   wire fall = clk_prev_r & ~clk_sync_r[1];
   wire dat = dat_sync_r[1];
   wire two_way = (mode != `KMH_MODE_UNI);

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         clk_sync_r <= 2'b11;
         dat_sync_r <= 2'b11;
         clk_prev_r <= 1'b1;
         state_r <= S_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r <= 11'h000;
         timer_r <= 32'h0;
         break_r <= 1'b0;
         cmd_ready <= 1'b0;
         cmd_done <= 1'b0;
         cmd_nak <= 1'b0;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
         rx_parity_err <= 1'b0;
         timeout_err <= 1'b0;
         irq <= 1'b0;
         link_clk_out <= 1'b0;
         link_clk_oe <= 1'b0;
         link_data_out <= 1'b0;
         link_data_oe <= 1'b0;
      end else begin
         clk_sync_r <= {clk_sync_r[0], link_clk_in};
         dat_sync_r <= {dat_sync_r[0], link_data_in};
         clk_prev_r <= clk_sync_r[1];
         cmd_done <= 1'b0;
         cmd_nak <= 1'b0;
         rx_valid <= 1'b0;
         rx_parity_err <= 1'b0;
         timeout_err <= 1'b0;
         irq <= 1'b0;
         cmd_ready <= 1'b0;
         case (state_r)
            S_IDLE: begin
               link_clk_oe <= 1'b0;
               link_data_oe <= 1'b0;
               timer_r <= 32'h0;
               bit_cnt_r <= 4'h0;
               cmd_ready <= two_way & ~fall;
               if (fall && !dat) begin
                  state_r <= S_RX;
               end else if (cmd_valid && two_way) begin
                  shift_r <= {1'b1, odd_par(cmd_data), cmd_data, 1'b0};
                  link_clk_oe <= 1'b1;
                  cmd_ready <= 1'b0;
                  state_r <= S_INH;
               end
            end
            S_RX: begin
               timer_r <= timer_r + 32'h1;
               if (fall) begin
                  timer_r <= 32'h0;
                  shift_r <= {dat, shift_r[10:1]};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                  if (bit_cnt_r == `KMH_FRAME_BITS - 4'h2) begin
                     state_r <= S_IDLE;
                     if (^shift_r[10:2] != 1'b1 || !dat) begin
                        rx_parity_err <= 1'b1;
                     end else if (shift_r[9:2] == 8'hF0 && translate && TRANSLATE_EN) begin
                        break_r <= 1'b1;
                     end else if (!lock) begin
                        rx_data <= translate ? xlate(shift_r[9:2], break_r) : shift_r[9:2];
                        break_r <= 1'b0;
                        rx_valid <= 1'b1;
                        irq <= 1'b1;
                        cmd_nak <= (shift_r[9:2] == 8'hFE);
                     end
                  end
               end else if (timer_r >= TIMEOUT_CYC) begin
                  timeout_err <= 1'b1;
                  state_r <= S_IDLE;
               end
            end
            S_INH: begin
               link_clk_oe <= 1'b1;
               link_clk_out <= 1'b0;
               timer_r <= timer_r + 32'h1;
               if (timer_r >= INHIBIT_CYC - 1) begin
                  timer_r <= 32'h0;
                  link_data_oe <= 1'b1;
                  link_data_out <= 1'b0;
                  link_clk_oe <= 1'b0;
                  bit_cnt_r <= 4'h0;
                  state_r <= S_TX;
               end
            end
            S_TX: begin
               timer_r <= timer_r + 32'h1;
               if (fall) begin
                  timer_r <= 32'h0;
                  // Start bit already on the line; each fall advances one bit.
                  shift_r <= {1'b1, shift_r[10:1]};
                  // Open drain: a one is sent by releasing the line to its pull-up.
                  link_data_out <= 1'b0;
                  link_data_oe <= ~shift_r[1];
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                  if (bit_cnt_r == `KMH_TX_BITS - 4'h1) begin
                     link_data_oe <= 1'b0;
                     state_r <= S_ACK;
                  end
               end else if (timer_r >= TIMEOUT_CYC) begin
                  link_data_oe <= 1'b0;
                  timeout_err <= 1'b1;
                  state_r <= S_IDLE;
               end
            end
            S_ACK: begin
               timer_r <= timer_r + 32'h1;
               if (fall) begin
                  timer_r <= 32'h0;
                  cmd_done <= 1'b1;
                  cmd_nak <= dat;
                  link_clk_oe <= 1'b1;
                  link_clk_out <= 1'b0;
                  state_r <= S_POST;
               end else if (timer_r >= TIMEOUT_CYC) begin
                  timeout_err <= 1'b1;
                  state_r <= S_IDLE;
               end
            end
            S_POST: begin
               // Clock held low briefly so the peripheral can process the byte.
               timer_r <= timer_r + 32'h1;
               if (timer_r >= INHIBIT_CYC - 1) begin
                  link_clk_oe <= 1'b0;
                  state_r <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// file: hdl/kmh_map.vh
// Constants for the keyboard and pointer serial link host.
`ifndef KMH_MAP_VH
`define KMH_MAP_VH
`define KMH_CLK_HZ 10000000
`define KMH_INHIBIT_NS 60000
`define KMH_INHIBIT_CYC ((`KMH_INHIBIT_NS * (`KMH_CLK_HZ / 1000000) + 999) / 1000)
`define KMH_TIMEOUT_CYC 20000
`define KMH_FRAME_BITS 4'd11
`define KMH_TX_BITS 4'd10
`define KMH_MODE_UNI 2'd1
`define KMH_MODE_DEF 2'd2
`define KMH_MODE_BI3 2'd3
`endif

// file: verif/kmh_port_monitor.sv
// Checker for the ports of one serial link host channel.
`timescale 1ns/1ns
module kmh_mon (
   // Clock and reset.
   input wire clock,
   input wire rstn,
   // Host side.
   input wire cmd_ready,
   input wire cmd_done,
   input wire rx_valid,
   input wire irq,
   input wire timeout_err,
   // Link pins.
   input wire link_clk_out,
   input wire link_clk_oe,
   input wire link_data_out,
   input wire link_data_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   property p_ck; link_clk_oe |-> !link_clk_out; endproperty
   a_ck: assert property (p_ck) else $error("clock pin driven high");
   property p_dt; link_data_oe |-> !link_data_out; endproperty
   a_dt: assert property (p_dt) else $error("data pin driven high");
   property p_st; $rose(link_data_oe) |-> ##[0:1] !link_clk_oe; endproperty
   a_st: assert property (p_st) else $error("clock held after start");
   property p_ih; cmd_done |-> ##[0:3] link_clk_oe; endproperty
   a_ih: assert property (p_ih) else $error("no inhibit after frame");
   property p_rd; link_clk_oe |-> !cmd_ready; endproperty
   a_rd: assert property (p_rd) else $error("ready while busy");
   property p_iq; rx_valid |-> ##[0:1] irq; endproperty
   a_iq: assert property (p_iq) else $error("no interrupt on byte");
   property p_to; timeout_err |-> ##[0:1] !link_data_oe; endproperty
   a_to: assert property (p_to) else $error("data held after timeout");
   property p_rx; rx_valid |-> !link_data_oe; endproperty
   a_rx: assert property (p_rx) else $error("host drove data in rx");
endmodule
bind kmh_port kmh_mon kmh_mon_i (.clock(clock), .rstn(rstn), .cmd_ready(cmd_ready),
   .cmd_done(cmd_done), .rx_valid(rx_valid), .irq(irq), .timeout_err(timeout_err),
   .link_clk_out(link_clk_out), .link_clk_oe(link_clk_oe),
   .link_data_out(link_data_out), .link_data_oe(link_data_oe));

// file: verif/kmh_dev.sv
// Behavioural keyboard on the two-wire link.
`timescale 1ns/1ns
module kmh_dev (
   // Resolved line levels.
   input wire kc,
   input wire kd,
   // Pull-downs of the model.
   output reg cp = 1'h0,
   output reg dp = 1'h0
);
   integer i;
   // Only the model makes clock pulses; between frames the line is high except while the host clamps it low around a command.
   task pulse;
      #200 cp = 1'h1;
      #400 cp = 1'h0;
      #200;
   endtask
   // A short count of bits leaves a broken frame for the timeout scenario.
   task send(input [7:0] b, input bad, input integer n);
      reg [10:0] f;
      f = {1'h1, ~^b ^ bad, b, 1'h0};
      wait (kc);
      // Keep every line change clear of the host's clock edges.
      #25;
      for (i = 0; i < n; i = i + 1) begin
         dp = !f[i];
         pulse;
      end
      dp = 1'h0;
   endtask
   task recv(output [9:0] r);
      integer j;
      wait (!kd && kc && !dp);
      #25;
      for (j = 0; j < 11; j = j + 1) begin
         dp = (j == 10);
         pulse;
         if (j < 10) r[j] = kd;
      end
      dp = 1'h0;
   endtask
endmodule

// file: verif/kmh_port_test.sv
// Self-checking bench for one serial link host channel.
`timescale 1ns/1ns
module kmh_port_test;
   reg clock = 1'h0;
   reg rstn = 1'h0;
   reg [1:0] mode = 2'h2;
   reg cmd_valid = 1'h0;
   reg lock = 1'h0;
   reg translate = 1'h0;
   reg [7:0] cmd_data = 8'h00;
   reg [7:0] last = 8'h00;
   wire cmd_ready, cmd_done, cmd_nak, rx_valid, rx_parity_err, timeout_err, irq;
   wire c_out, c_oe, d_out, d_oe, cp, dp;
   wire [7:0] rx_data;
   wire kc = !(c_oe | cp);
   wire kd = !(d_oe | dp);
   integer errors = 0, num_checks = 0, n_done = 0, n_nak = 0, n_pe = 0, n_to = 0;
   initial forever #50 clock = ~clock;
   kmh_port #(.TIMEOUT_CYC(2000)) kmh_port_i (.clock(clock), .rstn(rstn), .mode(mode),
      .lock(lock), .translate(translate), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
      .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_nak(cmd_nak), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_parity_err(rx_parity_err), .timeout_err(timeout_err),
      .irq(irq), .link_clk_in(kc), .link_clk_out(c_out), .link_clk_oe(c_oe),
      .link_data_in(kd), .link_data_out(d_out), .link_data_oe(d_oe));
   kmh_dev kmh_dev_i (.kc(kc), .kd(kd), .cp(cp), .dp(dp));
   always @(posedge clock) begin
      if (rx_valid) last <= rx_data;
      n_done <= n_done + cmd_done;
      n_nak <= n_nak + cmd_nak;
      n_pe <= n_pe + rx_parity_err;
      n_to <= n_to + timeout_err;
   end
   task chk(input [31:0] a, input [31:0] e);
      num_checks = num_checks + 1;
      if (a !== e) begin
         errors = errors + 1;
         $display("[ERR] %0t got %h exp %h", $time, a, e);
      end
   endtask
   // The clamp is timed from the first cycle it is seen, so it shows the full hold.
   task tx(input [7:0] b);
      reg [9:0] r;
      integer t;
      @(negedge clock);
      cmd_valid = 1'h1;
      cmd_data = b;
      // The request is taken when the clamp appears, even if ready never showed.
      for (t = 0; t < 900 && c_oe !== 1'h1; t = t + 1) @(negedge clock);
      cmd_valid = 1'h0;
      for (t = 0; t < 900 && d_oe !== 1'h1; t = t + 1) @(negedge clock);
      chk(t >= 600, 1);
      kmh_dev_i.recv(r);
      chk(r, {1'h1, ~^b, b});
      repeat (10) @(negedge clock);
   endtask
   task rx(input [7:0] b, input bad, input integer n);
      kmh_dev_i.send(b, bad, n);
      repeat (10) @(negedge clock);
   endtask
   task t_rx;
      rx(8'hA5, 1'h0, 11);
      chk(last, 8'hA5);
      chk(cmd_ready, 1);
      rx(8'h3C, 1'h1, 11);
      chk(n_pe, 1);
      $display("t_rx done");
   endtask
   task t_cmd;
      tx(8'hED);
      chk(n_done, 1);
      rx(8'hFA, 1'h0, 11);
      chk(last, 8'hFA);
      tx(8'h00);
      rx(8'hFE, 1'h0, 11);
      chk(n_nak, 1);
      fork
         rx(8'h5A, 1'h0, 11);
         begin
            // Ask only once the start bit is seen, so the frame must finish first.
            repeat (5) @(negedge clock);
            tx(8'h81);
         end
      join
      chk(last, 8'h5A);
      chk(n_done, 3);
      $display("t_cmd done");
   endtask
   task t_mode;
      mode = 2'h1;
      cmd_valid = 1'h1;
      rx(8'h1E, 1'h0, 11);
      chk({c_oe, d_oe}, 0);
      chk(last, 8'h1E);
      chk(cmd_ready, 0);
      cmd_valid = 1'h0;
      mode = 2'h2;
      lock = 1'h1;
      rx(8'h33, 1'h0, 11);
      chk(last, 8'h1E);
      lock = 1'h0;
      translate = 1'h1;
      rx(8'hF0, 1'h0, 11);
      rx(8'h12, 1'h0, 11);
      chk(last, 8'h92);
      translate = 1'h0;
      rx(8'h55, 1'h0, 4);
      repeat (2100) @(negedge clock);
      chk(n_to, 1);
      $display("t_mode done");
   endtask
   task summarize;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clock);
      rstn = 1'h1;
      t_rx;
      t_cmd;
      t_mode;
      summarize;
   end
   initial begin
      #5000000;
      errors = errors + 1;
      summarize;
   end
endmodule
